/* File: rtl/tmc_trigger.sv */
/*
 * tmc_trigger: one address/data match trigger with its comparator and
 * chain logic, registers reached over APB (zero wait states).
 * Assumes compare values are synchronous to pclk and that neighbouring
 * triggers are wired prev/next through the link and chain_ok ports.
 */
//
// Behaviour
// - unchained trigger takes its action whenever it matches
// - chained trigger that misses blocks the next trigger from matching
// - chain runs from first chain=1 after chain=0 up to next chain=0
// - only final member acts, and only when all members match together
// - write clearing dmode zeroes chain when next trigger has dmode set
// - write setting dmode is dropped if previous is dmode=0, chain=1
// - chain bit zeroed on writes that would exceed the supported length
// - mode 0 matches when a compare value equals the comparand
// - mode 1 compares top M bits, above comparand's lowest zero bit
// - all-ones low mask bits written clear the top one of them
// - mode 2 matches on unsigned greater or equal
// - mode 3 matches on unsigned less than
// - mode 4 masks low half with comparand high half, equals low half
// - mode 5 masks high half with comparand high half, equals low half
// - modes 8 and 9 invert modes 0 and 1 whenever a compare value is valid
// - modes 12 and 13 invert modes 4 and 5 whenever a compare value is valid
// - other match encodings are reserved and never held
// - comparisons use only low bits up to current mode width
// - data compares further narrowed to the access width
// - trigger matches in machine mode only while m bit is set
`timescale 1ns/10ps
module tmc_trigger
  import tmc_pkg::*;
#(
  parameter int NCMP = NCMP_DEF,
  parameter int MAX_MASK = MAX_MASK_DEF,
  parameter int MAX_CHAIN = MAX_CHAIN_DEF
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [NCMP-1:0] cmp_valid,
  input wire logic [NCMP-1:0][NRW-1:0] cmp_value,
  input wire logic cmp_is_data,
  input wire logic [2:0] access_log2,
  input wire logic [2:0] mode_log2,
  input wire logic priv_m,
  input wire logic lowpriv_en,
  input wire tmc_link_t prev_link,
  input wire tmc_link_t next_link,
  input wire logic chain_ok_in,
  input wire logic [DEPTH_W-1:0] chain_depth_in,
  output tmc_link_t self_link,
  output logic chain_ok_out,
  output logic [DEPTH_W-1:0] chain_depth_out,
  output logic match_q,
  output logic fire
);
  localparam logic [NRW-1:0] ONES = {NRW{1'b1}};
  localparam logic [NRW-1:0] LOW_MASK = NRW'((64'h1 << MAX_MASK) - 64'h1);

  logic [31:0] ctrl_r;
  logic [NRW-1:0] cmp_r;
  logic hit_r;
  logic raw_r;
  logic fire_r;
  logic [31:0] prdata_r;

  logic setup;
  logic wr_en;
  logic wr_ctrl;
  logic wr_cmp;
  logic wr_stat;
  logic mapped;
  logic [31:0] ctrl_nxt;
  logic [NRW-1:0] cmp_nxt;

  logic [3:0] mode;
  logic chain_bit;
  logic [2:0] w_log;
  logic [5:0] w_bits;
  logic [NRW-1:0] wmask;
  logic [NRW-1:0] cmpv;
  logic [NRW-1:0] napot_mask;
  logic [5:0] zero_idx;
  logic any_eq, any_nap, any_ge, any_lt, any_mlo, any_mhi;
  logic sel_hit;
  logic priv_ok;
  logic raw;
  logic [NRW-1:0] v;

  assign mode = ctrl_r[F_MATCH +: MATCH_W];
  assign chain_bit = ctrl_r[F_CHAIN];
  assign self_link = '{dmode: ctrl_r[F_DMODE], chain: chain_bit};

  // apb decode, always ready
  assign setup = psel && !penable;
  assign wr_en = psel && penable && pwrite;
  assign mapped = (paddr == OFF_CTRL) || (paddr == OFF_CMP) || (paddr == OFF_STAT);
  assign wr_ctrl = wr_en && (paddr == OFF_CTRL);
  assign wr_cmp = wr_en && (paddr == OFF_CMP);
  assign wr_stat = wr_en && (paddr == OFF_STAT);
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign prdata = prdata_r;

  // legalised control write
  always_comb begin
    ctrl_nxt = (ctrl_r & ~CTRL_WMASK) | (pwdata & CTRL_WMASK);
    if (!tmc_legal_mode(pwdata[F_MATCH +: MATCH_W])) begin
      ctrl_nxt[F_MATCH +: MATCH_W] = mode;
    end
    if (!pwdata[F_DMODE] && next_link.dmode) begin
      ctrl_nxt[F_CHAIN] = 1'b0;
    end
    if (pwdata[F_CHAIN] && (32'(chain_depth_in) + 32'd1 >= 32'(MAX_CHAIN))) begin
      ctrl_nxt[F_CHAIN] = 1'b0;
    end
    if (pwdata[F_DMODE] && !prev_link.dmode && prev_link.chain) begin
      ctrl_nxt = ctrl_r;
    end
  end

  // legalised comparand write
  always_comb begin
    cmp_nxt = pwdata[NRW-1:0];
    if ((pwdata[NRW-1:0] & LOW_MASK) == LOW_MASK) begin
      cmp_nxt[MAX_MASK-1] = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_r <= ctrl_nxt;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmp_r <= CMP_RST[NRW-1:0];
    end else if (wr_cmp) begin
      cmp_r <= cmp_nxt;
    end
  end

  // sticky hit: a fire in the clearing cycle wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hit_r <= 1'b0;
    end else if (fire) begin
      hit_r <= 1'b1;
    end else if (wr_stat && pwdata[ST_HIT]) begin
      hit_r <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      raw_r <= 1'b0;
      fire_r <= 1'b0;
    end else begin
      raw_r <= raw;
      fire_r <= fire;
    end
  end

  // read data captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h00000000;
    end else if (setup && !pwrite) begin
      unique case (paddr)
        OFF_CTRL: prdata_r <= ctrl_r;
        OFF_CMP: prdata_r <= 32'(cmp_r);
        OFF_STAT: prdata_r <= {29'h0, hit_r, fire_r, raw_r};
        default: prdata_r <= 32'h00000000;
      endcase
    end
  end

  // effective compare width
  always_comb begin
    w_log = 3'(NRW_LOG2);
    if (mode_log2 < w_log) begin
      w_log = mode_log2;
    end
    if (cmp_is_data && (access_log2 < w_log)) begin
      w_log = access_log2;
    end
    w_bits = 6'h01 << w_log;
    wmask = ONES >> (6'(NRW) - w_bits);
    cmpv = cmp_r & wmask;
  end

  // napot: compare only bits above the lowest zero of the comparand
  always_comb begin
    zero_idx = 6'(NRW - 1);
    for (int i = NRW - 1; i >= 0; i--) begin
      if (!cmpv[i]) begin
        zero_idx = 6'(i);
      end
    end
    napot_mask = ONES << (zero_idx + 6'h01);
  end

  always_comb begin
    any_eq = 1'b0;
    any_nap = 1'b0;
    any_ge = 1'b0;
    any_lt = 1'b0;
    any_mlo = 1'b0;
    any_mhi = 1'b0;
    v = '0;
    for (int k = 0; k < NCMP; k++) begin
      v = cmp_value[k] & wmask;
      if (cmp_valid[k]) begin
        any_eq |= (v == cmpv);
        any_nap |= (((v ^ cmpv) & napot_mask) == '0);
        any_ge |= (v >= cmpv);
        any_lt |= (v < cmpv);
        any_mlo |= ((v[HALF-1:0] & cmpv[NRW-1:HALF]) == cmpv[HALF-1:0]);
        any_mhi |= ((v[NRW-1:HALF] & cmpv[NRW-1:HALF]) == cmpv[HALF-1:0]);
      end
    end
  end

  always_comb begin
    unique case (mode)
      MM_EQ: sel_hit = any_eq;
      MM_NAPOT: sel_hit = any_nap;
      MM_GE: sel_hit = any_ge;
      MM_LT: sel_hit = any_lt;
      MM_MLO: sel_hit = any_mlo;
      MM_MHI: sel_hit = any_mhi;
      MM_NEQ: sel_hit = !any_eq;
      MM_NNAPOT: sel_hit = !any_nap;
      MM_NMLO: sel_hit = !any_mlo;
      MM_NMHI: sel_hit = !any_mhi;
      default: sel_hit = 1'b0;
    endcase
  end

  assign priv_ok = priv_m ? ctrl_r[F_M] : lowpriv_en;
  assign raw = (|cmp_valid) && priv_ok && sel_hit;
  // a missing predecessor match blocks this one
  assign match_q = raw && chain_ok_in;
  assign chain_ok_out = !chain_bit || match_q;
  assign fire = match_q && !chain_bit;
  assign chain_depth_out = chain_bit ? chain_depth_in + 1'b1 : '0;

  chk_fire_end: assert property (@(posedge pclk) disable iff (!presetn)
    fire |-> (!chain_bit && chain_ok_in && raw))
    else $error("fire without full chain match");

  chk_unchained_act: assert property (@(posedge pclk) disable iff (!presetn)
    (!chain_bit && raw && chain_ok_in) |-> fire)
    else $error("unchained match did not fire");

  chk_block_next: assert property (@(posedge pclk) disable iff (!presetn)
    (chain_bit && !match_q) |-> !chain_ok_out)
    else $error("chained miss did not block next trigger");

  chk_depth_count: assert property (@(posedge pclk) disable iff (!presetn)
    chain_bit |-> (chain_depth_out == chain_depth_in + 1'b1))
    else $error("chain depth wrong");

  chk_dmode_drop: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_ctrl && !pwdata[F_DMODE] && next_link.dmode && !prev_link.chain) |=> !chain_bit)
    else $error("chain kept after dmode cleared");

  chk_write_discard: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_ctrl && pwdata[F_DMODE] && !prev_link.dmode && prev_link.chain) |=> $stable(ctrl_r))
    else $error("conflicting dmode write taken");

  chk_chain_cap: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_ctrl && (32'(chain_depth_in) + 32'd1 >= 32'(MAX_CHAIN)) &&
     !(pwdata[F_DMODE] && !prev_link.dmode && prev_link.chain)) |=> !chain_bit)
    else $error("chain longer than supported");

  chk_mask_top: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_cmp && ((pwdata[NRW-1:0] & LOW_MASK) == LOW_MASK)) |=> !cmp_r[MAX_MASK-1])
    else $error("mask top bit not cleared");

  chk_mode_legal: assert property (@(posedge pclk) disable iff (!presetn)
    tmc_legal_mode(mode))
    else $error("reserved match mode held");

  chk_machine_gate: assert property (@(posedge pclk) disable iff (!presetn)
    (priv_m && !ctrl_r[F_M]) |-> !match_q)
    else $error("match in machine mode while disabled");

  chk_equal_hit: assert property (@(posedge pclk) disable iff (!presetn)
    (mode == MM_EQ && cmp_valid[0] && priv_ok && chain_ok_in &&
     ((cmp_value[0] & wmask) == cmpv)) |-> match_q)
    else $error("equal value missed");

  chk_invert_eq: assert property (@(posedge pclk) disable iff (!presetn)
    (mode == MM_NEQ && (|cmp_valid) && priv_ok && chain_ok_in) |-> (match_q != any_eq))
    else $error("not-equal is not the inverse");

  chk_ge_hit: assert property (@(posedge pclk) disable iff (!presetn)
    (mode == MM_GE && cmp_valid[0] && priv_ok && chain_ok_in &&
     ((cmp_value[0] & wmask) >= cmpv)) |-> match_q)
    else $error("greater or equal value missed");

  chk_lt_hit: assert property (@(posedge pclk) disable iff (!presetn)
    (mode == MM_LT && cmp_valid[0] && priv_ok && chain_ok_in &&
     ((cmp_value[0] & wmask) < cmpv)) |-> match_q)
    else $error("less than value missed");

  chk_mask_low: assert property (@(posedge pclk) disable iff (!presetn)
    (mode == MM_MLO && cmp_valid[0] && priv_ok && chain_ok_in &&
     ((cmp_value[0][HALF-1:0] & wmask[HALF-1:0] & cmpv[NRW-1:HALF]) == cmpv[HALF-1:0]))
    |-> match_q)
    else $error("mask low value missed");

  chk_mask_high: assert property (@(posedge pclk) disable iff (!presetn)
    (mode == MM_MHI && cmp_valid[0] && priv_ok && chain_ok_in &&
     ((cmp_value[0][NRW-1:HALF] & wmask[NRW-1:HALF] & cmpv[NRW-1:HALF]) == cmpv[HALF-1:0]))
    |-> match_q)
    else $error("mask high value missed");

  chk_napot_self: assert property (@(posedge pclk) disable iff (!presetn)
    (mode == MM_NAPOT && cmp_valid[0] && priv_ok && chain_ok_in &&
     ((cmp_value[0] & wmask) == cmpv)) |-> match_q)
    else $error("napot missed its own comparand");

  chk_invert_napot: assert property (@(posedge pclk) disable iff (!presetn)
    (mode == MM_NNAPOT && (|cmp_valid) && priv_ok && chain_ok_in) |-> (match_q != any_nap))
    else $error("not napot is not the inverse");

  chk_invert_mlo: assert property (@(posedge pclk) disable iff (!presetn)
    (mode == MM_NMLO && (|cmp_valid) && priv_ok && chain_ok_in) |-> (match_q != any_mlo))
    else $error("not mask low is not the inverse");

  chk_invert_mhi: assert property (@(posedge pclk) disable iff (!presetn)
    (mode == MM_NMHI && (|cmp_valid) && priv_ok && chain_ok_in) |-> (match_q != any_mhi))
    else $error("not mask high is not the inverse");

  chk_mode_width: assert property (@(posedge pclk) disable iff (!presetn)
    (mode_log2 < 3'(NRW_LOG2)) |-> !wmask[NRW-1])
    else $error("compare width not cut to mode width");

  chk_data_width: assert property (@(posedge pclk) disable iff (!presetn)
    (cmp_is_data && access_log2 < 3'(NRW_LOG2)) |-> !wmask[NRW-1])
    else $error("data compare not cut to access width");

  chk_no_valid: assert property (@(posedge pclk) disable iff (!presetn)
    !(|cmp_valid) |-> !match_q)
    else $error("match without a valid compare value");

  chk_unchained_pass: assert property (@(posedge pclk) disable iff (!presetn)
    !chain_bit |-> chain_ok_out)
    else $error("unchained trigger blocked the next one");

  chk_hit_set: assert property (@(posedge pclk) disable iff (!presetn)
    fire |=> hit_r)
    else $error("fire not recorded in hit");

  chk_hit_clear: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_stat && pwdata[ST_HIT] && !fire) |=> !hit_r)
    else $error("hit not cleared by write");

  cov_fire: cover property (@(posedge pclk) disable iff (!presetn) fire);
  cov_chain_block: cover property (@(posedge pclk) disable iff (!presetn)
    chain_bit && raw && !chain_ok_in);
  cov_hit_clear: cover property (@(posedge pclk) disable iff (!presetn)
    hit_r ##1 !hit_r);
  cov_napot: cover property (@(posedge pclk) disable iff (!presetn)
    mode == MM_NAPOT && match_q);
  cov_chain_end: cover property (@(posedge pclk) disable iff (!presetn)
    (chain_depth_in != '0) && fire);
endmodule

/* File: rtl/tmc_pkg.sv */
/*
 * tmc_pkg: constants and types for the trigger match and chain block.
 * Assumes a 32-bit native register width and an APB register port.
 */
package tmc_pkg;
  localparam int NRW = 32;
  localparam int NRW_LOG2 = 5;
  localparam int HALF = NRW / 2;
  localparam int MAX_MASK_DEF = 6;
  localparam int MAX_CHAIN_DEF = 4;
  localparam int NCMP_DEF = 2;
  localparam int DEPTH_W = 4;

  localparam logic [11:0] OFF_CTRL = 12'h000;
  localparam logic [11:0] OFF_CMP = 12'h004;
  localparam logic [11:0] OFF_STAT = 12'h008;

  localparam int F_M = 6;
  localparam int F_MATCH = 7;
  localparam int MATCH_W = 4;
  localparam int F_CHAIN = 11;
  localparam int F_DMODE = 27;
  localparam logic [31:0] CTRL_WMASK = 32'h08000fc0;

  localparam int ST_RAW = 0;
  localparam int ST_FIRE = 1;
  localparam int ST_HIT = 2;

  localparam logic [31:0] CTRL_RST = 32'h00000000;
  localparam logic [31:0] CMP_RST = 32'h00000000;

  localparam logic [3:0] MM_EQ = 4'h0;
  localparam logic [3:0] MM_NAPOT = 4'h1;
  localparam logic [3:0] MM_GE = 4'h2;
  localparam logic [3:0] MM_LT = 4'h3;
  localparam logic [3:0] MM_MLO = 4'h4;
  localparam logic [3:0] MM_MHI = 4'h5;
  localparam logic [3:0] MM_NEQ = 4'h8;
  localparam logic [3:0] MM_NNAPOT = 4'h9;
  localparam logic [3:0] MM_NMLO = 4'hc;
  localparam logic [3:0] MM_NMHI = 4'hd;

  typedef struct packed {
    logic dmode;
    logic chain;
  } tmc_link_t;

  function automatic logic tmc_legal_mode(input logic [3:0] m);
    return (m <= MM_MHI) || (m == MM_NEQ) || (m == MM_NNAPOT) ||
           (m == MM_NMLO) || (m == MM_NMHI);
  endfunction
endpackage

/* File: testbench/tmc_hart_model.sv */
/* tmc_hart_model: hart pipeline stand-in presenting compare values.
   Assumes the bench requests at most one value a cycle on lane 0. */
`timescale 1ns/10ps
module tmc_hart_model
  import tmc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic req_valid,
  input wire logic [NRW-1:0] req_value,
  output logic [NCMP_DEF-1:0] cmp_valid,
  output logic [NCMP_DEF-1:0][NRW-1:0] cmp_value
);
  // idle lanes toggle so a stale value can never pass for a match
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmp_valid <= '0;
      cmp_value <= '0;
    end else begin
      cmp_valid <= {1'b0, req_valid};
      cmp_value[1] <= ~cmp_value[1];
      cmp_value[0] <= req_valid ? req_value : ~cmp_value[0];
    end
  end
endmodule

/* File: testbench/test_trigger_match_chain_logic.sv */
/* test_trigger_match_chain_logic: self-checking bench for tmc_trigger.
   Assumes zero-wait APB and combinational match outputs. */
`timescale 1ns/10ps
module test_trigger_match_chain_logic;
  import tmc_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, req_value;
  logic req_valid, cmp_is_data, priv_m, lowpriv_en, chain_ok_in, chain_ok_out, match_q, fire;
  logic [NCMP_DEF-1:0] cmp_valid;
  logic [NCMP_DEF-1:0][NRW-1:0] cmp_value;
  logic [2:0] access_log2, mode_log2;
  tmc_link_t prev_link, next_link, self_link;
  logic [DEPTH_W-1:0] chain_depth_in, chain_depth_out;
  int n_mismatch = 0;
  int checked = 0;

  tmc_hart_model i_hart (.pclk(pclk), .presetn(presetn), .req_valid(req_valid),
    .req_value(req_value), .cmp_valid(cmp_valid), .cmp_value(cmp_value));
  tmc_trigger i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cmp_valid(cmp_valid), .cmp_value(cmp_value),
    .cmp_is_data(cmp_is_data), .access_log2(access_log2), .mode_log2(mode_log2),
    .priv_m(priv_m), .lowpriv_en(lowpriv_en), .prev_link(prev_link), .next_link(next_link),
    .chain_ok_in(chain_ok_in), .chain_depth_in(chain_depth_in), .self_link(self_link),
    .chain_ok_out(chain_ok_out), .chain_depth_out(chain_depth_out), .match_q(match_q),
    .fire(fire));

  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  task automatic tally_and_finish;
    if (n_mismatch == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  function automatic logic [31:0] ctl(input logic [3:0] mm, input logic ch, input logic dm);
    return (32'(dm) << F_DMODE) | (32'(ch) << F_CHAIN) | (32'(mm) << F_MATCH) | 32'h40;
  endfunction

  function automatic logic hit(input logic [3:0] mm, input logic [31:0] c, input logic [31:0] v);
    logic r;
    int z;
    z = 0;
    while (z < 31 && c[z]) z++;
    case (mm[2:0])
      3'h0: r = v == c;
      3'h1: r = ((v ^ c) >> (z + 1)) == 32'h0;
      3'h2: r = v >= c;
      3'h3: r = v < c;
      3'h4: r = (v[15:0] & c[31:16]) == c[15:0];
      default: r = (v[31:16] & c[31:16]) == c[15:0];
    endcase
    return r ^ mm[3];
  endfunction

  // present one value on lane 0 and judge the combinational outputs
  task automatic look(input logic [31:0] v, input logic em, input logic ef, input logic eo);
    @(posedge pclk);
    req_valid <= 1'b1;
    req_value <= v;
    @(posedge pclk);
    #1;
    chk({match_q, fire, chain_ok_out}, {em, ef, eo});
    @(posedge pclk);
    req_valid <= 1'b0;
  endtask

  task automatic t_reset_and_codes;
    logic [3:0] keep;
    apb(1'b0, OFF_CTRL, 32'h0);
    chk(rd, CTRL_RST);
    apb(1'b0, 12'h0fc, 32'h0);
    chk({rd[30:0], err}, 32'h1);
    keep = MM_EQ;
    for (int c = 0; c < 16; c++) begin
      apb(1'b1, OFF_CTRL, ctl(4'(c), 1'b0, 1'b0));
      if (c <= 5 || c == 8 || c == 9 || c == 12 || c == 13) keep = 4'(c);
      apb(1'b0, OFF_CTRL, 32'h0);
      chk(rd, ctl(keep, 1'b0, 1'b0));
    end
  endtask

  task automatic t_modes;
    logic [31:0] cs[4] = '{32'h0000100f, 32'h0000100f, 32'hff001200, 32'hff001200};
    logic [31:0] vs[4] = '{32'h00001003, 32'h0000100f, 32'h12991234, 32'h00000034};
    logic [3:0] ms[10] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h8, 4'h9, 4'hc, 4'hd};
    for (int p = 0; p < 4; p++) begin
      apb(1'b1, OFF_CMP, cs[p]);
      for (int k = 0; k < 10; k++) begin
        apb(1'b1, OFF_CTRL, ctl(ms[k], 1'b0, 1'b0));
        look(vs[p], hit(ms[k], cs[p], vs[p]), hit(ms[k], cs[p], vs[p]), 1'b1);
      end
    end
    apb(1'b1, OFF_CMP, 32'h0000003f);
    apb(1'b0, OFF_CMP, 32'h0);
    chk(rd & 32'hffffffe0, 32'h0);
  endtask

  task automatic t_chain;
    @(posedge pclk) chain_depth_in <= 4'h1;
    apb(1'b1, OFF_CMP, 32'h0000abcd);
    apb(1'b1, OFF_CTRL, ctl(MM_EQ, 1'b1, 1'b0));
    look(32'h0000abcd, 1'b1, 1'b0, 1'b1);
    look(32'h0000abce, 1'b0, 1'b0, 1'b0);
    chk(32'(chain_depth_out), 32'h2);
    apb(1'b1, OFF_CTRL, ctl(MM_EQ, 1'b0, 1'b0));
    #1;
    chk(32'(chain_depth_out), 32'h0);
    @(posedge pclk) chain_ok_in <= 1'b0;
    look(32'h0000abcd, 1'b0, 1'b0, 1'b1);
    @(posedge pclk) chain_ok_in <= 1'b1;
    apb(1'b1, OFF_CTRL, ctl(MM_EQ, 1'b0, 1'b0) & 32'hffffffbf);
    look(32'h0000abcd, 1'b0, 1'b0, 1'b1);
    @(posedge pclk) priv_m <= 1'b0;
    look(32'h0000abcd, 1'b0, 1'b0, 1'b1);
    @(posedge pclk) lowpriv_en <= 1'b1;
    look(32'h0000abcd, 1'b1, 1'b1, 1'b1);
    @(posedge pclk) {priv_m, lowpriv_en} <= 2'b10;
  endtask

  task automatic t_links;
    @(posedge pclk) next_link <= '{dmode: 1'b1, chain: 1'b0};
    apb(1'b1, OFF_CTRL, ctl(MM_EQ, 1'b1, 1'b0));
    apb(1'b0, OFF_CTRL, 32'h0);
    chk(32'(rd[F_CHAIN]), 32'h0);
    @(posedge pclk) next_link <= '{dmode: 1'b0, chain: 1'b0};
    apb(1'b1, OFF_CTRL, ctl(MM_EQ, 1'b1, 1'b0));
    apb(1'b0, OFF_CTRL, 32'h0);
    chk(32'(rd[F_CHAIN]), 32'h1);
    @(posedge pclk) chain_depth_in <= 4'h3;
    apb(1'b1, OFF_CTRL, ctl(MM_EQ, 1'b1, 1'b0));
    apb(1'b0, OFF_CTRL, 32'h0);
    chk(32'(rd[F_CHAIN]), 32'h0);
    @(posedge pclk) prev_link <= '{dmode: 1'b0, chain: 1'b1};
    apb(1'b1, OFF_CTRL, ctl(MM_LT, 1'b0, 1'b1));
    apb(1'b0, OFF_CTRL, 32'h0);
    chk(rd, ctl(MM_EQ, 1'b0, 1'b0));
    // previous chain seen clear before dmode is set
    @(posedge pclk) prev_link <= '{dmode: 1'b0, chain: 1'b0};
    apb(1'b1, OFF_CTRL, ctl(MM_LT, 1'b0, 1'b1));
    #1;
    chk(32'(self_link), 32'h2);
    @(posedge pclk) chain_depth_in <= 4'h0;
  endtask

  task automatic t_data_width;
    @(posedge pclk) cmp_is_data <= 1'b1;
    apb(1'b1, OFF_CMP, 32'h00000055);
    apb(1'b1, OFF_CTRL, ctl(MM_EQ, 1'b0, 1'b0));
    look(32'hab000055, 1'b1, 1'b1, 1'b1);
    @(posedge pclk) access_log2 <= 3'h5;
    look(32'hab000055, 1'b0, 1'b0, 1'b1);
    @(posedge pclk) {cmp_is_data, mode_log2} <= {1'b0, 3'h4};
    look(32'hab000055, 1'b1, 1'b1, 1'b1);
    @(posedge pclk) mode_log2 <= 3'h5;
  endtask

  // sticky hit, then last-cycle raw and fire seen through the status word
  task automatic t_status;
    apb(1'b0, OFF_STAT, 32'h0);
    chk(rd, 32'h1 << ST_HIT);
    apb(1'b1, OFF_STAT, 32'h1 << ST_HIT);
    apb(1'b0, OFF_STAT, 32'h0);
    chk(rd, 32'h0);
    look(32'h00000055, 1'b1, 1'b1, 1'b1);
    apb(1'b0, OFF_STAT, 32'h0);
    chk(rd, (32'h1 << ST_HIT) | (32'h1 << ST_FIRE) | (32'h1 << ST_RAW));
  endtask

  initial begin
    {psel, penable, pwrite, req_valid, cmp_is_data, lowpriv_en, presetn} = '0;
    {paddr, pwdata, req_value, prev_link, next_link, chain_depth_in} = '0;
    {priv_m, chain_ok_in, access_log2, mode_log2} = {1'b1, 1'b1, 3'h3, 3'h5};
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_reset_and_codes();
    t_modes();
    t_chain();
    t_links();
    t_data_width();
    t_status();
    tally_and_finish();
  end

  initial begin
    #400000;
    n_mismatch++;
    tally_and_finish();
  end
endmodule
